// [shared/mkf_cfg.svh]
// Constants for the MPLS/IP key field builder
`ifndef MKF_CFG_SVH
`define MKF_CFG_SVH

// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MKF_OFS_CTRL      12'h000
`define MKF_OFS_SKIP      12'h004
`define MKF_OFS_STATUS    12'h008
`define MKF_OFS_COUNT     12'h00c

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define MKF_CTRL_USE_CL_DSCP  0
`define MKF_CTRL_LOOKUP_SKIP0 1
`define MKF_CTRL_LOOKUP_SKIP1 2
`define MKF_CTRL_RST          32'h0000_0000
`define MKF_SKIP_RST          16'h0000

// ----------------------------------------------------------------------
// Key encodings
// ----------------------------------------------------------------------
`define MKF_POS_NONE      3'h5
`define MKF_POS_LAST      3'h3
`define MKF_TTL_EXPIRE    8'h01
`define MKF_IHL_PLAIN     4'h5
`define MKF_RSV_LABEL_MAX 20'h0000f
`define MKF_ETH_HDR_BYTES 8'h0e
`define MKF_VLAN_BYTES    8'h04
`define MKF_CUSTOM_BYTES  15
`define MKF_IP_PAYLOAD_OFS 20

`endif

// [shared/mkf_pkg.sv]
// Types for the MPLS/IP key field builder
package mkf_pkg;

    // Quad-word key layout selector
    typedef enum logic [1:0] {
        MKF_LABEL_LOOKUP_LAYOUT   = 2'b00,
        MKF_TRIPLE_LABEL_LAYOUT   = 2'b01,
        MKF_PURE_FIVE_TUPLE_LAYOUT = 2'b10,
        MKF_CUSTOM_LAYOUT         = 2'b11
    } mkf_key_type_e;

    // Builder sequencing
    typedef enum logic [0:0] {
        MKF_IDLE = 1'b0,
        MKF_DONE = 1'b1
    } mkf_state_e;

    typedef struct packed {
        mkf_state_e    state;
        logic [31:0]   ctrl;
        logic [15:0]   skip;
        logic [31:0]   count;
        logic          pready;
        logic [31:0]   prdata;
        logic          pslverr;
        logic          key_valid;
        mkf_key_type_e quad_key_type;
        logic          first_lookup;
        logic [19:0]   third_label_value;
        logic [2:0]    third_traffic_class;
        logic          third_bottom_of_stack;
        logic          third_ttl_expired;
        logic [3:0]    reserved_label_value;
        logic [31:0]   control_word_after_stack;
        logic [2:0]    reserved_label_position;
        logic          ipv4_fragment_flag;
        logic          ipv4_non_first_fragment;
        logic          ipv4_options_flag;
        logic [5:0]    dscp_key_field;
        logic [31:0]   destination_ip_field;
        logic [31:0]   source_ip_overloaded_field;
        logic [7:0]    ip_protocol_field;
        logic [7:0]    range_match_mask;
        logic [31:0]   five_tuple_payload_word;
        logic [119:0]  custom_payload_window;
    } mkf_state_s;

endpackage : mkf_pkg

// [src/mkf_key_builder.sv]
// MPLS and IP portion of the quad-word classification key
`timescale 1ns/1ns
`include "mkf_cfg.svh"

module mkf_key_builder (
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    // APB slave
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [11:0]   paddr,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic               pready,
    output logic [31:0]        prdata,
    output logic               pslverr,
    // Parsed frame from the ingress parser
    input  wire logic          frame_valid,
    input  wire logic          lookup_index,
    input  wire logic [1:0]    key_type_sel,
    input  wire logic [127:0]  label_stack,
    input  wire logic [31:0]   word_after_stack,
    input  wire logic          ethertype_frame_flag,
    input  wire logic          ip_or_snap_flag,
    input  wire logic          ipv4_frame_flag,
    input  wire logic          ipv4_more_fragments,
    input  wire logic [12:0]   ipv4_fragment_offset,
    input  wire logic [3:0]    ipv4_header_length,
    input  wire logic [5:0]    frame_dscp,
    input  wire logic [5:0]    classified_dscp,
    input  wire logic [31:0]   frame_dip,
    input  wire logic [31:0]   frame_sip,
    input  wire logic [7:0]    frame_protocol,
    input  wire logic [7:0]    llc_control,
    input  wire logic [23:0]   snap_pid,
    input  wire logic [7:0]    range_mask_in,
    input  wire logic [255:0]  frame_bytes,
    input  wire logic [7:0]    ip_header_start,
    input  wire logic [7:0]    frame_pointer,
    input  wire logic          pointer_from_action,
    input  wire logic [1:0]    vlan_tag_count,
    // Key to the match engine
    output logic               key_valid,
    output logic [1:0]         quad_key_type,
    output logic               first_lookup,
    output logic [19:0]        third_label_value,
    output logic [2:0]         third_traffic_class,
    output logic               third_bottom_of_stack,
    output logic               third_ttl_expired,
    output logic [3:0]         reserved_label_value,
    output logic [31:0]        control_word_after_stack,
    output logic [2:0]         reserved_label_position,
    output logic               ipv4_fragment_flag,
    output logic               ipv4_non_first_fragment,
    output logic               ipv4_options_flag,
    output logic [5:0]         dscp_key_field,
    output logic [31:0]        destination_ip_field,
    output logic [31:0]        source_ip_overloaded_field,
    output logic [7:0]         ip_protocol_field,
    output logic [7:0]         range_match_mask,
    output logic [31:0]        five_tuple_payload_word,
    output logic [119:0]       custom_payload_window
);

    mkf_pkg::mkf_state_s st_reg;
    mkf_pkg::mkf_state_s st_next;

    // ------------------------------------------------------------------
    // Frame byte picker
    // ------------------------------------------------------------------
    // Byte 0 sits in the top lane, network order
    function automatic logic [7:0] pick(input logic [255:0] b,
                                        input logic [7:0]   idx);
        logic [7:0] r;
        r = 8'h00;
        if (idx < 8'd32) begin
            r = b[8'(8'd31 - idx) * 8 +: 8];
        end
        return r;
    endfunction : pick

    // ------------------------------------------------------------------
    // Combinational key build and APB
    // ------------------------------------------------------------------
    logic [31:0] ent;
    logic [7:0]  base;
    logic [7:0]  pl;
    logic        skip_en;
    logic        found;
    logic        cw_found;

    always_comb begin
        st_next = st_reg;
        ent = 32'h0;
        base = 8'h00;
        pl = 8'h00;
        skip_en = 1'b0;
        found = 1'b0;
        cw_found = 1'b0;
        st_next.pready = 1'b0;
        st_next.pslverr = 1'b0;
        st_next.key_valid = 1'b0;

        // Completes in the access cycle after one wait state
        if (psel && penable && !st_reg.pready) begin
            st_next.pready = 1'b1;
            st_next.prdata = 32'h0;
            unique case (paddr)
                `MKF_OFS_CTRL: begin
                    st_next.prdata = st_reg.ctrl;
                    if (pwrite && pstrb[0]) begin
                        st_next.ctrl = {29'h0, pwdata[2:0]};
                    end
                end
                `MKF_OFS_SKIP: begin
                    st_next.prdata = {16'h0, st_reg.skip};
                    if (pwrite) begin
                        if (pstrb[0]) st_next.skip[7:0] = pwdata[7:0];
                        if (pstrb[1]) st_next.skip[15:8] = pwdata[15:8];
                    end
                end
                `MKF_OFS_STATUS: begin
                    st_next.prdata = {24'h0, st_reg.reserved_label_position,
                                      st_reg.third_ttl_expired,
                                      st_reg.ipv4_fragment_flag,
                                      st_reg.ipv4_options_flag,
                                      st_reg.quad_key_type};
                    st_next.pslverr = pwrite;
                end
                `MKF_OFS_COUNT: begin
                    st_next.prdata = st_reg.count;
                    st_next.pslverr = pwrite;
                end
                default: begin
                    // Unmapped addresses answer with an error
                    st_next.pslverr = 1'b1;
                end
            endcase
        end

        st_next.state = frame_valid ? mkf_pkg::MKF_DONE
                                    : mkf_pkg::MKF_IDLE;
        if (frame_valid) begin
            st_next.key_valid = 1'b1;
            st_next.count = st_reg.count + 32'h1;
            st_next.quad_key_type = mkf_pkg::mkf_key_type_e'(key_type_sel);
            st_next.first_lookup = ~lookup_index;

            ent = label_stack[63:32];
            st_next.third_label_value = ent[31:12];
            st_next.third_traffic_class = ent[11:9];
            st_next.third_bottom_of_stack = ent[8];
            st_next.third_ttl_expired = (ent[7:0] <= `MKF_TTL_EXPIRE);

            st_next.reserved_label_position = `MKF_POS_NONE;
            st_next.reserved_label_value = 4'h0;
            st_next.control_word_after_stack = word_after_stack;
            skip_en = st_reg.ctrl[lookup_index ? `MKF_CTRL_LOOKUP_SKIP1
                                               : `MKF_CTRL_LOOKUP_SKIP0];
            // walk from top (position 0) downward
            for (int i = 0; i < 4; i++) begin
                ent = label_stack[(3 - i) * 32 +: 32];
                if (!found && ent[31:12] <= `MKF_RSV_LABEL_MAX) begin
                    st_next.reserved_label_value = ent[15:12];
                    st_next.reserved_label_position = 3'(i);
                    // skip allowed by either enable; else stop
                    if (!(st_reg.skip[ent[15:12]] || skip_en) ||
                        3'(i) == `MKF_POS_LAST) begin
                        found = 1'b1;
                    end
                end
                if (!cw_found && ent[8]) begin
                    cw_found = 1'b1;
                    if (i < 3) begin
                        st_next.control_word_after_stack =
                            label_stack[(2 - i) * 32 +: 32];
                    end
                end
                if (ent[8]) found = 1'b1;
            end
            // value only meaningful with a position seen
            if (st_next.reserved_label_position == `MKF_POS_NONE) begin
                st_next.reserved_label_value = 4'h0;
            end

            st_next.ipv4_fragment_flag = ipv4_frame_flag &&
                (ipv4_more_fragments || ipv4_fragment_offset != 13'h0);
            st_next.ipv4_non_first_fragment = ipv4_frame_flag &&
                (ipv4_fragment_offset != 13'h0);
            st_next.ipv4_options_flag = ipv4_frame_flag &&
                (ipv4_header_length > `MKF_IHL_PLAIN);
            st_next.dscp_key_field =
                st_reg.ctrl[`MKF_CTRL_USE_CL_DSCP] ? classified_dscp
                                                   : frame_dscp;
            st_next.destination_ip_field = frame_dip;
            st_next.ip_protocol_field = frame_protocol;
            // range inputs already remapped by the parser
            st_next.range_match_mask = range_mask_in;

            if (!ethertype_frame_flag && !ip_or_snap_flag) begin
                st_next.source_ip_overloaded_field = {llc_control,
                    pick(frame_bytes, frame_pointer),
                    pick(frame_bytes, 8'(frame_pointer + 8'h1)),
                    pick(frame_bytes, 8'(frame_pointer + 8'h2))};
            end else if (!ethertype_frame_flag) begin
                st_next.source_ip_overloaded_field = {snap_pid,
                    pick(frame_bytes, frame_pointer)};
            end else if (ip_or_snap_flag) begin
                st_next.source_ip_overloaded_field = frame_sip;
            end else begin
                st_next.source_ip_overloaded_field = {
                    pick(frame_bytes, frame_pointer),
                    pick(frame_bytes, 8'(frame_pointer + 8'h1)),
                    pick(frame_bytes, 8'(frame_pointer + 8'h2)),
                    pick(frame_bytes, 8'(frame_pointer + 8'h3))};
            end

            pl = 8'(ip_header_start + 8'(`MKF_IP_PAYLOAD_OFS));
            for (int k = 0; k < 4; k++) begin
                st_next.five_tuple_payload_word[(3 - k) * 8 +: 8] =
                    pick(frame_bytes, 8'(pl + 8'(k)));
            end

            // custom window from pointer or after Ethernet layer
            base = pointer_from_action ? frame_pointer :
                8'(`MKF_ETH_HDR_BYTES +
                   8'({6'h0, vlan_tag_count}) * `MKF_VLAN_BYTES);
            for (int k = 0; k < `MKF_CUSTOM_BYTES; k++) begin
                st_next.custom_payload_window[(14 - k) * 8 +: 8] =
                    pick(frame_bytes, 8'(base + 8'(k)));
            end
        end
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
            st_reg.reserved_label_position <= `MKF_POS_NONE;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state register
    assign pready = st_reg.pready;
    assign prdata = st_reg.prdata;
    assign pslverr = st_reg.pslverr;
    assign key_valid = st_reg.key_valid;
    assign quad_key_type = st_reg.quad_key_type;
    assign first_lookup = st_reg.first_lookup;
    assign third_label_value = st_reg.third_label_value;
    assign third_traffic_class = st_reg.third_traffic_class;
    assign third_bottom_of_stack = st_reg.third_bottom_of_stack;
    assign third_ttl_expired = st_reg.third_ttl_expired;
    assign reserved_label_value = st_reg.reserved_label_value;
    assign control_word_after_stack = st_reg.control_word_after_stack;
    assign reserved_label_position = st_reg.reserved_label_position;
    assign ipv4_fragment_flag = st_reg.ipv4_fragment_flag;
    assign ipv4_non_first_fragment = st_reg.ipv4_non_first_fragment;
    assign ipv4_options_flag = st_reg.ipv4_options_flag;
    assign dscp_key_field = st_reg.dscp_key_field;
    assign destination_ip_field = st_reg.destination_ip_field;
    assign source_ip_overloaded_field = st_reg.source_ip_overloaded_field;
    assign ip_protocol_field = st_reg.ip_protocol_field;
    assign range_match_mask = st_reg.range_match_mask;
    assign five_tuple_payload_word = st_reg.five_tuple_payload_word;
    assign custom_payload_window = st_reg.custom_payload_window;

endmodule : mkf_key_builder

// [tb/mkf_engine_model.sv]
// Match engine stand-in that counts delivered keys
`timescale 1ns/1ns
module mkf_engine_model (
    input  wire logic          clk_sys,
    input  wire logic          arst_n,
    input  wire logic          key_valid,
    output logic [31:0]        keys_seen
);
    // Engine takes a key in the cycle it is offered, never stalls
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            keys_seen <= 32'h0;
        end else if (key_valid === 1'b1) begin
            keys_seen <= keys_seen + 32'h1;
        end
    end
endmodule : mkf_engine_model

// [tb/mkf_key_builder_asserts.sv]
// Port-level assertion checker for the key builder
`timescale 1ns/1ns
module mkf_key_builder_asserts (
    input wire logic           clk_sys,
    input wire logic           arst_n,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pready,
    input wire logic           frame_valid,
    input wire logic           lookup_index,
    input wire logic [1:0]     key_type_sel,
    input wire logic [127:0]   label_stack,
    input wire logic           ipv4_frame_flag,
    input wire logic           ipv4_more_fragments,
    input wire logic [12:0]    ipv4_fragment_offset,
    input wire logic [31:0]    frame_dip,
    input wire logic           key_valid,
    input wire logic [1:0]     quad_key_type,
    input wire logic           first_lookup,
    input wire logic [19:0]    third_label_value,
    input wire logic           third_ttl_expired,
    input wire logic [3:0]     reserved_label_value,
    input wire logic [2:0]     reserved_label_position,
    input wire logic           ipv4_fragment_flag,
    input wire logic           ipv4_non_first_fragment,
    input wire logic [31:0]    destination_ip_field
);
    // -----------------------------------------------------------------
    // Key timing and field checks
    // -----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    AST_KEY_PULSE: assert property (key_valid == $past(frame_valid))
        else $error("key pulse not one cycle after frame");
    AST_LAYOUT: assert property (frame_valid |=> quad_key_type ==
        $past(key_type_sel)) else $error("key type mismatch");
    AST_FIRST: assert property (frame_valid |=> first_lookup !=
        $past(lookup_index)) else $error("lookup select wrong");
    AST_THIRD_LBL: assert property (frame_valid |=>
        third_label_value == $past(label_stack[63:44]))
        else $error("third label value wrong");
    AST_TTL_EXP: assert property (frame_valid |=> third_ttl_expired ==
        ($past(label_stack[39:32]) <= 8'h01)) else $error("ttl flag wrong");
    AST_FRAG: assert property (frame_valid && ipv4_frame_flag |=>
        ipv4_fragment_flag == ($past(ipv4_more_fragments)
        || $past(ipv4_fragment_offset) != 13'h0)) else $error("frag wrong");
    AST_NONFIRST: assert property (frame_valid && ipv4_frame_flag |=>
        ipv4_non_first_fragment == ($past(ipv4_fragment_offset) != 13'h0))
        else $error("non-first fragment flag wrong");
    AST_POS_CODE: assert property (reserved_label_position != 3'h4)
        else $error("reserved position code used");
    AST_RSV_VAL: assert property (reserved_label_position == 3'h5 |->
        reserved_label_value == 4'h0) else $error("value without label");
    AST_DIP: assert property (frame_valid |=> destination_ip_field ==
        $past(frame_dip)) else $error("destination field wrong");
    AST_HOLD: assert property (!frame_valid |=>
        $stable(destination_ip_field)) else $error("field moved while idle");
    // Slave inserts exactly one wait state, then a single pulse
    AST_APB_WAIT: assert property (psel && penable && !pready |=> pready)
        else $error("apb answer late");
    AST_APB_PULSE: assert property (pready |=> !pready)
        else $error("apb ready longer than one cycle");

    COV_KEY: cover property (frame_valid ##1 frame_valid ##1 key_valid);
    COV_FRAG: cover property (key_valid && ipv4_non_first_fragment);
    COV_RSV: cover property (key_valid && reserved_label_position == 3'h3);
endmodule : mkf_key_builder_asserts

bind mkf_key_builder mkf_key_builder_asserts mkf_key_builder_asserts_i (.*);

// [tb/tb_mkf_key_builder.sv]
// Self-checking bench for the MPLS/IP key builder
`timescale 1ns/1ns
module tb_mkf_key_builder;
    localparam int KW = 308;
    logic clk_sys = 1'b0, arst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, keys_seen;
    logic [3:0] pstrb, ipv4_header_length, reserved_label_value;
    logic frame_valid, lookup_index, ethertype_frame_flag, ip_or_snap_flag;
    logic ipv4_frame_flag, ipv4_more_fragments, pointer_from_action;
    logic [1:0] key_type_sel, vlan_tag_count, quad_key_type;
    logic [127:0] label_stack;
    logic [31:0] word_after_stack, frame_dip, frame_sip;
    logic [12:0] ipv4_fragment_offset;
    logic [5:0] frame_dscp, classified_dscp, dscp_key_field;
    logic [7:0] frame_protocol, llc_control, range_mask_in, ip_header_start;
    logic [7:0] frame_pointer, ip_protocol_field, range_match_mask;
    logic [23:0] snap_pid;
    logic [255:0] frame_bytes;
    logic key_valid, first_lookup, third_bottom_of_stack, third_ttl_expired;
    logic ipv4_fragment_flag, ipv4_non_first_fragment, ipv4_options_flag;
    logic [19:0] third_label_value;
    logic [2:0] third_traffic_class, reserved_label_position;
    logic [31:0] control_word_after_stack, destination_ip_field;
    logic [31:0] source_ip_overloaded_field, five_tuple_payload_word;
    logic [119:0] custom_payload_window;
    logic [31:0] lfsr = 32'h0000_0013;
    logic use_cl = 1'b0;
    logic [KW-1:0] exp_q[$];
    int n_errors = 0, checks = 0;
    // Reserved labels 3, 7, 5, 9 down the stack, no bottom bit
    localparam logic [127:0] LS_RSV = {20'h00003, 12'h440, 20'h00007,
        12'h202, 20'h00005, 12'ha01, 20'h00009, 12'he00};

    mkf_key_builder mkf_key_builder_i (.*);
    mkf_engine_model mkf_engine_model_i (.*);

    always #5 clk_sys = ~clk_sys;

    // -----------------------------------------------------------------
    // Helpers
    // -----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        for (int i = 0; i < 32; i++) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        end
        return lfsr;
    endfunction : rnd

    // Out-of-range bytes read as zero, as the parser presents them
    function automatic logic [7:0] bt(input int n);
        return (n < 32) ? frame_bytes[(31 - n) * 8 +: 8] : 8'h00;
    endfunction : bt

    function automatic logic [KW-1:0] exp_key(input logic [2:0] pos,
                                              input logic [3:0] val);
        logic [31:0] cw, sip, pw, ftp;
        logic [119:0] cus;
        logic v4;
        int st;
        v4 = ipv4_frame_flag;
        cw = label_stack[104] ? label_stack[95:64] : label_stack[72] ?
            label_stack[63:32] : label_stack[40] ? label_stack[31:0] :
            word_after_stack;
        st = pointer_from_action ? frame_pointer : 14 + 4 * vlan_tag_count;
        for (int i = 0; i < 4; i++) begin
            pw = {pw[23:0], bt(frame_pointer + i)};
            ftp = {ftp[23:0], bt(ip_header_start + 20 + i)};
        end
        for (int i = 0; i < 15; i++) begin
            cus = {cus[111:0], bt(st + i)};
        end
        if (!ethertype_frame_flag) begin
            sip = ip_or_snap_flag ? {snap_pid, pw[31:24]}
                                  : {llc_control, pw[31:8]};
        end else begin
            sip = ip_or_snap_flag ? frame_sip : pw;
        end
        return {label_stack[63:40], label_stack[39:32] <= 8'h01, val, cw, pos,
            v4 && (ipv4_more_fragments || ipv4_fragment_offset != 13'h0),
            v4 && ipv4_fragment_offset != 13'h0, v4 && ipv4_header_length > 5,
            use_cl ? classified_dscp : frame_dscp, frame_dip, sip,
            frame_protocol, range_mask_in, ftp, cus, key_type_sel,
            !lookup_index};
    endfunction : exp_key

    task automatic chk(input logic [KW-1:0] got, input logic [KW-1:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim

    // APB master: hold the request until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic err);
        int i;
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (i == 20) begin
            n_errors++;
            end_sim();
        end else begin
            chk(pslverr, err);
            if (!wr && !err) chk(prdata, d);
            psel <= 1'b0; penable <= 1'b0;
        end
    endtask : apb

    // One frame strobe with random fields; expectation queued 1 ns after the edge
    task automatic frame(input logic [127:0] ls, input logic [2:0] pos,
                         input logic [3:0] val);
        logic [31:0] r;
        logic [255:0] fb;
        @(posedge clk_sys);
        r = rnd();
        label_stack <= ls; lookup_index <= r[0]; key_type_sel <= r[2:1];
        ethertype_frame_flag <= r[3]; ip_or_snap_flag <= r[4];
        ipv4_frame_flag <= r[3] & r[4] & r[5]; ipv4_more_fragments <= r[6];
        ipv4_fragment_offset <= r[7] ? 13'h0 : {5'h0, r[15:8]};
        ipv4_header_length <= r[19:16]; pointer_from_action <= r[20];
        vlan_tag_count <= r[22:21]; ip_header_start <= {5'h0, r[25:23]};
        frame_pointer <= {4'h0, r[29:26]}; frame_valid <= 1'b1;
        r = rnd();
        frame_dscp <= r[5:0]; classified_dscp <= r[11:6];
        range_mask_in <= r[19:12]; frame_protocol <= r[27:20];
        r = rnd();
        llc_control <= r[7:0]; snap_pid <= r[31:8];
        word_after_stack <= rnd(); frame_dip <= rnd(); frame_sip <= rnd();
        for (int i = 0; i < 8; i++) fb[i * 32 +: 32] = rnd();
        frame_bytes <= fb;
        #1 exp_q.push_back(exp_key(pos, val));
    endtask : frame

    task automatic idle();
        @(posedge clk_sys);
        frame_valid <= 1'b0;
    endtask : idle

    // Key monitor: oldest expectation against each key pulse
    always @(posedge clk_sys) begin
        if (key_valid === 1'b1) begin
            if (exp_q.size() == 0) chk(1'b1, 1'b0);
            else chk({third_label_value, third_traffic_class,
                third_bottom_of_stack, third_ttl_expired, reserved_label_value,
                control_word_after_stack, reserved_label_position,
                ipv4_fragment_flag, ipv4_non_first_fragment, ipv4_options_flag,
                dscp_key_field, destination_ip_field, source_ip_overloaded_field,
                ip_protocol_field, range_match_mask, five_tuple_payload_word,
                custom_payload_window, quad_key_type, first_lookup},
                exp_q.pop_front());
        end
    end

    // -----------------------------------------------------------------
    // Main sequence
    // -----------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, frame_valid} = '0;
        pstrb = 4'hf;
        {label_stack, word_after_stack, frame_dip, frame_sip, frame_bytes} = '0;
        {lookup_index, key_type_sel, ethertype_frame_flag, ip_or_snap_flag,
         ipv4_frame_flag, ipv4_more_fragments, ipv4_fragment_offset} = '0;
        {ipv4_header_length, frame_dscp, classified_dscp, frame_protocol,
         llc_control, snap_pid, range_mask_in, ip_header_start} = '0;
        {frame_pointer, pointer_from_action, vlan_tag_count} = '0;
        repeat (5) @(posedge clk_sys);
        arst_n <= 1'b1;
        apb(1'b0, 12'h000, 32'h0, 1'b0);
        apb(1'b0, 12'h004, 32'h0, 1'b0);
        apb(1'b1, 12'h000, 32'h1, 1'b0);
        apb(1'b0, 12'h000, 32'h1, 1'b0);
        apb(1'b1, 12'h008, 32'hff, 1'b1);
        apb(1'b0, 12'h010, 32'h0, 1'b1);
        $display("register test done");
        use_cl = 1'b1;
        repeat (20) frame({rnd() | 32'h8000_0000, rnd() | 32'h8000_0000,
            rnd() | 32'h8000_0000, rnd() | 32'h8000_0000}, 3'h5, 4'h0);
        idle();
        apb(1'b1, 12'h000, 32'h0, 1'b0);
        use_cl = 1'b0;
        repeat (20) frame({rnd() | 32'h8000_0000, rnd() | 32'h8000_0000,
            rnd() | 32'h8000_0000, rnd() | 32'h8000_0000}, 3'h5, 4'h0);
        idle();
        $display("random frame test done");
        frame(LS_RSV, 3'h0, 4'h3);
        idle();
        apb(1'b1, 12'h004, 32'h8, 1'b0);
        frame(LS_RSV, 3'h1, 4'h7);
        idle();
        apb(1'b1, 12'h004, 32'h0, 1'b0);
        apb(1'b1, 12'h000, 32'h7, 1'b0);
        use_cl = 1'b1;
        frame(LS_RSV, 3'h3, 4'h9);
        idle();
        $display("reserved label test done");
        repeat (3) @(posedge clk_sys);
        apb(1'b0, 12'h00c, 32'h2b, 1'b0);
        chk(keys_seen, 32'h2b);
        // Status mirrors the last key: position 3, third entry expired
        apb(1'b0, 12'h008, {24'h0, 3'h3, 1'b1, ipv4_frame_flag &&
            (ipv4_more_fragments || ipv4_fragment_offset != 13'h0),
            ipv4_frame_flag && ipv4_header_length > 4'h5, key_type_sel},
            1'b0);
        chk(exp_q.size(), 0);
        $display("count test done");
        end_sim();
    end
endmodule : tb_mkf_key_builder
